// ==== hdl/aadcir_top.sv ====
// Notes on behaviour
// - polarity bit zero drives the pin active low, one drives it active high
// - mode zero asserts the pin while any unmasked latched source is set
// - mode two repeats a 2 ms active pulse every 4 ms while unmasked set
// - mode three gives a 2 ms pulse per unmasked event; an event during a pulse restarts it
// - readback select one hides masked sources in latched status readback
// - mask resets to all ones; zero enables a source, one masks it
// - mask bits 7..3: clock error, lock, saturation, vad up, vad down
// - latched bits 7, 6, 5 set on clock error, lock, saturation; self clear
// - latched bits 4 and 3 set on vad power up and power down; self clear
// - latched status is read only, resets to zero, bits 2..0 read zero
// - configuration register holds polarity, mode, readback; resets zero
`timescale 1ns/1ps
`default_nettype none
`include "aadcir_cfg.svh"

module aadcir_top #(
  parameter int unsigned PULSE_CYCLES  = `AADCIR_PULSE_CYCLES,
  parameter int unsigned PERIOD_CYCLES = `AADCIR_PERIOD_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // event sources, one-cycle pulses from device logic
  input  wire logic       ev_clock_error,
  input  wire logic       ev_pll_lock,
  input  wire logic       ev_mix_saturation,
  input  wire logic       ev_vad_power_up,
  input  wire logic       ev_vad_power_down,
  // interrupt pin
  output logic            irq_pin
);

  localparam int unsigned LO = `AADCIR_SRC_LO;
  localparam int unsigned HI = `AADCIR_SRC_HI;

  aadcir_pkg::aadcir_regs_t cur;
  aadcir_pkg::aadcir_regs_t next_cur;

  logic [7:0] src;
  logic [7:0] unmasked;
  logic [7:0] shown;
  logic [7:0] next_latched;
  logic       rd_latched;
  logic       wr_config;
  logic       wr_mask;
  logic       level_active;
  logic       shot_trigger;
  logic       repeat_hold;
  logic       timer_active;
  logic       pin_active;

  ////////////////////////////////////////////////////////////////////////////
  // event sources gathered at their status positions
  always_comb begin
    src                           = 8'h00;
    src[`AADCIR_SRC_CLK_ERR]      = ev_clock_error;
    src[`AADCIR_SRC_LOCK]         = ev_pll_lock;
    src[`AADCIR_SRC_MIX_SAT]      = ev_mix_saturation;
    src[`AADCIR_SRC_VAD_UP]       = ev_vad_power_up;
    src[`AADCIR_SRC_VAD_DOWN]     = ev_vad_power_down;
  end

  assign unmasked   = cur.latched & ~cur.mask;
  assign shown      = cur.rdbk ? unmasked : cur.latched;
  assign rd_latched = reg_rd && (reg_addr == `AADCIR_ADDR_LATCHED);
  assign wr_config  = reg_wr && (reg_addr == `AADCIR_ADDR_CONFIG);
  assign wr_mask    = reg_wr && (reg_addr == `AADCIR_ADDR_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // latched status, one slice per source; a new event wins over the clear
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_latch
      if (gi >= LO && gi <= HI) begin : g_src
        assign next_latched[gi] = src[gi] |
          (cur.latched[gi] & ~(rd_latched & shown[gi]));
      end else begin : g_rsvd
        assign next_latched[gi] = 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // pin drive by event mode
  // mode one is not to be used; it falls back to level behaviour
  assign level_active = |unmasked[HI:LO];
  assign repeat_hold  = (cur.mode == `AADCIR_MODE_REPEAT) &&
                        (|unmasked[HI:LO]);
  assign shot_trigger = (cur.mode == `AADCIR_MODE_SINGLE) &&
                        (|(src[HI:LO] & ~cur.mask[HI:LO]));

  aadcir_pulse_timer #(
    .CNT_W         (`AADCIR_CNT_W),
    .PULSE_CYCLES  (PULSE_CYCLES),
    .PERIOD_CYCLES (PERIOD_CYCLES)
  ) u_timer (
    .clk     (clk),
    .rst     (rst),
    .trigger (shot_trigger),
    .hold    (repeat_hold),
    .active  (timer_active)
  );

  always_comb begin
    case (cur.mode)
      `AADCIR_MODE_LEVEL:  pin_active = level_active;
      `AADCIR_MODE_UNUSED: pin_active = level_active;
      `AADCIR_MODE_REPEAT: pin_active = timer_active;
      `AADCIR_MODE_SINGLE: pin_active = timer_active;
      default:             pin_active = level_active;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes, reads and next state
  always_comb begin
    next_cur         = cur;
    next_cur.latched = next_latched;
    next_cur.rvalid  = reg_rd;
    if (wr_config) begin
      next_cur.pol  = reg_wdata[`AADCIR_CFG_POL_BIT];
      next_cur.mode = reg_wdata[`AADCIR_CFG_MODE_HI:`AADCIR_CFG_MODE_LO];
      next_cur.rdbk = reg_wdata[`AADCIR_CFG_RDBK_BIT];
    end
    // reserved mask bits are stored as written; host keeps them at one
    if (wr_mask) begin
      next_cur.mask = reg_wdata;
    end
    if (reg_rd) begin
      case (reg_addr)
        `AADCIR_ADDR_CONFIG: begin
          next_cur.rdata = 8'h00;
          next_cur.rdata[`AADCIR_CFG_POL_BIT] = cur.pol;
          next_cur.rdata[`AADCIR_CFG_MODE_HI:`AADCIR_CFG_MODE_LO] = cur.mode;
          next_cur.rdata[`AADCIR_CFG_RDBK_BIT] = cur.rdbk;
        end
        `AADCIR_ADDR_MASK:    next_cur.rdata = cur.mask;
        `AADCIR_ADDR_LATCHED: next_cur.rdata = shown;
        default:              next_cur.rdata = 8'h00;
      endcase
    end
    // pin registered so it carries no combinational glitch
    next_cur.irq_pin = cur.pol ? pin_active : ~pin_active;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur.pol     <= 1'b0;
      cur.mode    <= `AADCIR_MODE_LEVEL;
      cur.rdbk    <= 1'b0;
      cur.mask    <= `AADCIR_RST_MASK;
      cur.latched <= `AADCIR_RST_LATCHED;
      cur.rdata   <= `AADCIR_RST_RDATA;
      cur.rvalid  <= 1'b0;
      cur.irq_pin <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata  = cur.rdata;
  assign reg_rvalid = cur.rvalid;
  assign irq_pin    = cur.irq_pin;

endmodule : aadcir_top

`default_nettype wire

// ==== hdl/aadcir_cfg.svh ====
`ifndef AADCIR_CFG_SVH
`define AADCIR_CFG_SVH

// register addresses on the internal register port
`define AADCIR_ADDR_CONFIG     8'h32
`define AADCIR_ADDR_MASK       8'h33
`define AADCIR_ADDR_LATCHED    8'h36

// reset values
`define AADCIR_RST_CONFIG      8'h00
`define AADCIR_RST_MASK        8'hFF
`define AADCIR_RST_LATCHED     8'h00
`define AADCIR_RST_RDATA       8'h00

// configuration field positions
`define AADCIR_CFG_POL_BIT     7
`define AADCIR_CFG_MODE_HI     6
`define AADCIR_CFG_MODE_LO     5
`define AADCIR_CFG_RDBK_BIT    2

// source bit positions in mask and latched status
`define AADCIR_SRC_CLK_ERR     7
`define AADCIR_SRC_LOCK        6
`define AADCIR_SRC_MIX_SAT     5
`define AADCIR_SRC_VAD_UP      4
`define AADCIR_SRC_VAD_DOWN    3
`define AADCIR_SRC_LO          3
`define AADCIR_SRC_HI          7

// event mode field codes
`define AADCIR_MODE_LEVEL      2'h0
`define AADCIR_MODE_UNUSED     2'h1
`define AADCIR_MODE_REPEAT     2'h2
`define AADCIR_MODE_SINGLE     2'h3

// pin timing
`define AADCIR_CLK_KHZ         10000
`define AADCIR_PULSE_US        2000
`define AADCIR_PERIOD_US       4000
`define AADCIR_PULSE_CYCLES    ((`AADCIR_PULSE_US * `AADCIR_CLK_KHZ) / 1000)
`define AADCIR_PERIOD_CYCLES   ((`AADCIR_PERIOD_US * `AADCIR_CLK_KHZ) / 1000)
`define AADCIR_CNT_W           16

`endif

// ==== hdl/aadcir_pkg.sv ====
`default_nettype none
package aadcir_pkg;

  typedef enum logic [1:0] {
    AADCIR_TMR_IDLE,
    AADCIR_TMR_SHOT,
    AADCIR_TMR_REPEAT
  } aadcir_tmr_state_t;

  typedef struct packed {
    aadcir_tmr_state_t state;
    logic [15:0]       cnt;
  } aadcir_tmr_t;

  typedef struct packed {
    logic       pol;
    logic [1:0] mode;
    logic       rdbk;
    logic [7:0] mask;
    logic [7:0] latched;
    logic [7:0] rdata;
    logic       rvalid;
    logic       irq_pin;
  } aadcir_regs_t;

endpackage : aadcir_pkg

`default_nettype wire

// ==== hdl/aadcir_pulse_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "aadcir_cfg.svh"

module aadcir_pulse_timer #(
  parameter int unsigned CNT_W         = `AADCIR_CNT_W,
  parameter int unsigned PULSE_CYCLES  = `AADCIR_PULSE_CYCLES,
  parameter int unsigned PERIOD_CYCLES = `AADCIR_PERIOD_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control
  input  wire logic trigger,
  input  wire logic hold,
  // pulse out
  output logic      active
);

  localparam logic [CNT_W-1:0] PULSE_LAST  = CNT_W'(PULSE_CYCLES - 1);
  localparam logic [CNT_W-1:0] PULSE_LEN   = CNT_W'(PULSE_CYCLES);
  localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_CYCLES - 1);

  aadcir_pkg::aadcir_tmr_t cur;
  aadcir_pkg::aadcir_tmr_t next_cur;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_cur = cur;
    case (cur.state)
      aadcir_pkg::AADCIR_TMR_IDLE: begin
        if (hold) begin
          next_cur.state = aadcir_pkg::AADCIR_TMR_REPEAT;
          next_cur.cnt   = '0;
        end else if (trigger) begin
          next_cur.state = aadcir_pkg::AADCIR_TMR_SHOT;
          next_cur.cnt   = '0;
        end
      end
      aadcir_pkg::AADCIR_TMR_SHOT: begin
        // a new event restarts the pulse so each one gets its full width
        if (hold) begin
          next_cur.state = aadcir_pkg::AADCIR_TMR_REPEAT;
        end else if (trigger) begin
          next_cur.cnt = '0;
        end else if (cur.cnt >= PULSE_LAST) begin
          next_cur.state = aadcir_pkg::AADCIR_TMR_IDLE;
          next_cur.cnt   = '0;
        end else begin
          next_cur.cnt = cur.cnt + 1'b1;
        end
      end
      aadcir_pkg::AADCIR_TMR_REPEAT: begin
        if (hold) begin
          // 2 ms on, 2 ms off for as long as the cause remains
          if (cur.cnt == PERIOD_LAST) begin
            next_cur.cnt = '0;
          end else begin
            next_cur.cnt = cur.cnt + 1'b1;
          end
        end else if (cur.cnt < PULSE_LAST) begin
          // finish the running pulse rather than leave a runt on the pin
          next_cur.state = aadcir_pkg::AADCIR_TMR_SHOT;
          next_cur.cnt   = cur.cnt + 1'b1;
        end else begin
          next_cur.state = aadcir_pkg::AADCIR_TMR_IDLE;
          next_cur.cnt   = '0;
        end
      end
      default: begin
        next_cur.state = aadcir_pkg::AADCIR_TMR_IDLE;
        next_cur.cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur.state <= aadcir_pkg::AADCIR_TMR_IDLE;
      cur.cnt   <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign active = (cur.state != aadcir_pkg::AADCIR_TMR_IDLE) &&
                  (cur.cnt < PULSE_LEN);

endmodule : aadcir_pulse_timer

`default_nettype wire

// ==== verif/aadcir_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module aadcir_monitor #(
  parameter int unsigned PULSE_CYCLES  = 20000,
  parameter int unsigned PERIOD_CYCLES = 40000
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  // events and pin
  input wire logic       ev_clock_error,
  input wire logic       ev_pll_lock,
  input wire logic       ev_mix_saturation,
  input wire logic       ev_vad_power_up,
  input wire logic       ev_vad_power_down,
  input wire logic       irq_pin
);
  logic [7:0]  cfg;
  logic [7:0]  msk;
  logic [1:0]  quiet;
  logic [15:0] run;
  logic        act;
  // shadow of config and mask; quiet lets the pin settle after a write
  assign act = irq_pin == cfg[7];
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg   <= 8'h00;
      msk   <= 8'hFF;
      quiet <= 2'h0;
      run   <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == 8'h32) cfg <= reg_wdata;
      if (reg_wr && reg_addr == 8'h33) msk <= reg_wdata;
      quiet <= reg_wr ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
      run   <= act ? run + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  property p_rd_answer;
    reg_rd |=> reg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered");
  property p_no_stray;
    reg_rvalid |-> $past(reg_rd);
  endproperty
  a_no_stray: assert property (p_no_stray)
    else $error("answer without read");
  property p_unmapped;
    reg_rd && !(reg_addr inside {8'h32, 8'h33, 8'h36}) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_resv;
    reg_rd && reg_addr == 8'h36 |=> reg_rdata[2:0] == 3'h0;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved status bits set");
  property p_cfg;
    reg_rd && reg_addr == 8'h32 |=> reg_rdata == ($past(cfg) & 8'hE4);
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("config readback wrong");
  property p_mask;
    reg_rd && reg_addr == 8'h33 |=> reg_rdata == $past(msk);
  endproperty
  a_mask: assert property (p_mask)
    else $error("mask readback wrong");
  property p_level_on;
    (cfg[6:5] == 2'h0 && ev_clock_error && !msk[7] && !reg_wr) ##1
      (!reg_wr) |-> ##1 act;
  endproperty
  a_level_on: assert property (p_level_on)
    else $error("level pin not active");
  property p_masked;
    quiet == 2'h3 && cfg[6:5] == 2'h0 && msk[7:3] == 5'h1F |-> !act;
  endproperty
  a_masked: assert property (p_masked)
    else $error("pin active while all masked");
  property p_rep;
    quiet == 2'h3 && cfg[6:5] == 2'h2 && $fell(act) |-> run == PULSE_CYCLES;
  endproperty
  a_rep: assert property (p_rep)
    else $error("repeat pulse length wrong");
  property p_shot;
    quiet == 2'h3 && cfg[6:5] == 2'h3 && $fell(act) |-> run >= PULSE_CYCLES;
  endproperty
  a_shot: assert property (p_shot)
    else $error("single pulse too short");
endmodule : aadcir_monitor
bind aadcir_top aadcir_monitor #(
  .PULSE_CYCLES(PULSE_CYCLES), .PERIOD_CYCLES(PERIOD_CYCLES)) u_mon (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .ev_clock_error(ev_clock_error),
  .ev_pll_lock(ev_pll_lock), .ev_mix_saturation(ev_mix_saturation),
  .ev_vad_power_up(ev_vad_power_up), .ev_vad_power_down(ev_vad_power_down),
  .irq_pin(irq_pin));
`default_nettype wire

// ==== verif/aadcir_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module aadcir_host_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pin and its programmed active level
  input  wire logic irq_pin,
  input  wire logic pol,
  // seen activity
  output var int    pulses,
  output var int    act_cycles
);
  logic act_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      act_q      <= 1'b0;
      pulses     <= 0;
      act_cycles <= 0;
    end else begin
      act_q <= irq_pin === pol;
      if (irq_pin === pol && !act_q) pulses <= pulses + 1;
      if (irq_pin === pol) act_cycles <= act_cycles + 1;
    end
  end
endmodule : aadcir_host_model
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk, rst, reg_wr, reg_rd, pol, reg_rvalid, irq_pin;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, lf, m, v;
  logic [4:0] ev;
  logic [7:0] q[$];
  int         errors, tests_run, pulses, act_cycles, p0, a0;
  aadcir_top #(.PULSE_CYCLES(4), .PERIOD_CYCLES(8)) dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .ev_clock_error(ev[4]), .ev_pll_lock(ev[3]),
    .ev_mix_saturation(ev[2]), .ev_vad_power_up(ev[1]),
    .ev_vad_power_down(ev[0]), .irq_pin(irq_pin));
  aadcir_host_model host (.clk(clk), .rst(rst), .irq_pin(irq_pin),
    .pol(pol), .pulses(pulses), .act_cycles(act_cycles));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rdq(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rdq
  task fire(input logic [4:0] b);
    @(posedge clk);
    ev <= b;
    @(posedge clk);
    ev <= 5'h00;
  endtask : fire
  task pin(input logic e);
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, irq_pin}, {7'h00, e});
  endtask : pin
  task end_of_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////
  // read answers are matched in issue order
  always @(posedge clk) begin
    if (reg_rvalid === 1'b1) chk(reg_rdata, q.size() ? q.pop_front() : 8'hxx);
  end
  initial begin
    repeat (4000) @(posedge clk);
    errors++;
    end_of_test();
  end
  initial begin
    {rst, reg_wr, reg_rd, pol} = 4'h8;
    {reg_addr, reg_wdata, ev} = 21'h0;
    {lf, errors, tests_run} = {8'h17, 64'h0};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    pin(1'b1);
    rdq(8'h32, 8'h00);
    rdq(8'h33, 8'hFF);
    rdq(8'h34, 8'h00);
    wr(8'h36, 8'hFF);
    rdq(8'h36, 8'h00);
    wr(8'h32, 8'hFF);
    rdq(8'h32, 8'hE4);
    wr(8'h32, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(8'h33, ~(8'h80 >> i));
      fire(5'h10 >> i);
      pin(1'b0);
      rdq(8'h36, 8'h80 >> i);
      pin(1'b1);
      rdq(8'h36, 8'h00);
    end
    fire(5'h10);
    // event recurs in the read cycle: the set must win over the clear
    fork
      fire(5'h10);
      rdq(8'h36, 8'h80);
    join
    rdq(8'h36, 8'h80);
    rdq(8'h36, 8'h00);
    wr(8'h33, 8'hFF);
    fire(5'h1F);
    pin(1'b1);
    rdq(8'h36, 8'hF8);
    for (int n = 0; n < 8; n++) begin
      lf = lfsr(lf);
      v = lf;
      lf = lfsr(lf);
      m = lf;
      wr(8'h33, {m[4:0], 3'h7});
      wr(8'h32, {5'h00, v[7], 2'h0});
      fire(v[4:0]);
      rdq(8'h36, {v[4:0] & (v[7] ? ~m[4:0] : 5'h1F), 3'h0});
      wr(8'h32, 8'h00);
      rdq(8'h36, {v[4:0] & (v[7] ? m[4:0] : 5'h00), 3'h0});
    end
    pol <= 1'b1;
    wr(8'h32, 8'h80);
    pin(1'b0);
    wr(8'h33, 8'h7F);
    fire(5'h10);
    pin(1'b1);
    rdq(8'h36, 8'h80);
    wr(8'h32, 8'hE0);
    p0 = pulses;
    a0 = act_cycles;
    fire(5'h10);
    repeat (16) @(posedge clk);
    chk(8'(pulses - p0), 8'h01);
    chk(8'(act_cycles - a0), 8'h04);
    rdq(8'h36, 8'h80);
    wr(8'h32, 8'hC0);
    p0 = pulses;
    fire(5'h10);
    repeat (22) @(posedge clk);
    chk(8'(pulses - p0), 8'h03);
    rdq(8'h36, 8'h80);
    repeat (8) @(posedge clk);
    p0 = pulses;
    repeat (16) @(posedge clk);
    chk(8'(pulses - p0), 8'h00);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
